// ### sac_ctrl.sv
// Conversion control and successive-approximation sequencer.
// Assumes control pins and comparator come from outside the clock domain.
`timescale 1ns/1ps
`include "sac_defs.svh"
module sac_ctrl (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	// Control pins
	input wire logic chip_enable_in,
	input wire logic chip_select_n_in,
	input wire logic read_convert_n_in,
	// Analog front end
	input wire logic comparator_below_in,
	output logic [11:0] capacitive_dac_out,
	output logic sample_hold_out,
	// Status and data pins
	output logic conversion_busy_flag_out,
	output logic [11:0] result_out,
	output logic [11:0] result_oe_out
);
	sac_pkg::sac_state_e state;
	sac_pkg::sac_state_e next_state;
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic start_prev;
	logic cmp_a;
	logic cmp_b;
	sac_pkg::sac_word_t sar;
	sac_pkg::sac_word_t trial;
	sac_pkg::sac_word_t latch;
	logic [1:0] acq_cnt;
	logic tick;
	logic [1:0] sync_fill;
	logic [11:0] conv_len;
	wire ce_s = sync_b[0];
	wire cs_n_s = sync_b[1];
	wire rc_n_s = sync_b[2];
	// Start condition: all three active, last arrival makes the edge
	wire start_level = ce_s && !cs_n_s && !rc_n_s;
	wire start_pulse = start_level && !start_prev;
	wire idle = (state == sac_pkg::SAC_IDLE);
	wire run = !idle;
	wire read_en = idle && ce_s && !cs_n_s && rc_n_s;
	wire last_bit = trial[0];
	wire start_accept = idle && start_pulse;
	wire step_acq = (state == sac_pkg::SAC_ACQ) && tick;
	wire step_conv = (state == sac_pkg::SAC_CONV) && tick;
	wire acq_done = (acq_cnt == 2'(`SAC_ACQ_CYCLES - 1));
	// Trial bit kept while the DAC sum sits below the input
	wire [11:0] next_sar = cmp_b ? (sar | trial) : sar;
	localparam int unsigned CONV_LEN = (`SAC_RES_BITS + `SAC_ACQ_CYCLES) * `SAC_STEP_CYCLES;
	always_comb begin
		next_state = state;
		case (state)
			sac_pkg::SAC_IDLE: begin
				if (start_pulse) next_state = sac_pkg::SAC_ACQ;
			end
			sac_pkg::SAC_ACQ: begin
				if (step_acq && acq_done) next_state = sac_pkg::SAC_CONV;
			end
			sac_pkg::SAC_CONV: begin
				if (tick && last_bit) next_state = sac_pkg::SAC_IDLE;
			end
			default: next_state = sac_pkg::SAC_IDLE;
		endcase
	end
	sac_tick u_tick (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.clk_en_in(clk_en_in),
		.run_in(run),
		.tick_out(tick)
	);
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync_a <= 3'h0;
			sync_b <= 3'h0;
			sync_fill <= 2'h0;
			cmp_a <= 1'b0;
			cmp_b <= 1'b0;
		end else if (clk_en_in) begin
			sync_a <= {read_convert_n_in, chip_select_n_in, chip_enable_in};
			sync_b <= sync_a;
			sync_fill <= {sync_fill[0], 1'b1};
			cmp_a <= comparator_below_in;
			cmp_b <= cmp_a;
		end
	end
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= sac_pkg::SAC_IDLE;
			start_prev <= 1'b1;
		end else if (clk_en_in) begin
			state <= next_state;
			// No edge is seen until the synchronisers hold pin values
			start_prev <= sync_fill[1] ? start_level : 1'b1;
		end
	end
	// Successive-approximation register and trial bit
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sar <= `SAC_RESULT_RST;
			trial <= 12'h000;
		end else if (clk_en_in) begin
			if (start_accept) begin
				sar <= 12'h000;
				trial <= 12'h000;
			end else if (step_acq && acq_done) begin
				trial <= 12'h800;
			end else if (step_conv) begin
				sar <= next_sar;
				trial <= trial >> 1;
			end
		end
	end
	// Acquisition cycle counter
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			acq_cnt <= 2'h0;
		end else if (clk_en_in) begin
			if (start_accept) begin
				acq_cnt <= 2'h0;
			end else if (step_acq) begin
				acq_cnt <= acq_cnt + 2'h1;
			end
		end
	end
	// Output latch, loaded at the last trial only
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			latch <= `SAC_RESULT_RST;
		end else if (clk_en_in && step_conv && last_bit) begin
			latch <= next_sar;
		end
	end
	// Busy-time counter for the conversion length check
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			conv_len <= 12'h000;
		end else if (clk_en_in) begin
			conv_len <= idle ? 12'h000 : conv_len + 12'h001;
		end
	end
	assign capacitive_dac_out = sar | trial;
	assign sample_hold_out = (state == sac_pkg::SAC_CONV);
	assign conversion_busy_flag_out = run;
	assign result_out = latch;
	assign result_oe_out = {12{read_en}};
	// Sequencer checks
	busy_during_conv_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(state != sac_pkg::SAC_IDLE) |-> conversion_busy_flag_out)
		else $error("busy low during conversion");
	no_data_busy_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		conversion_busy_flag_out |-> (result_oe_out == 12'h000))
		else $error("data driven while busy");
	start_clears_sar_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(idle && start_pulse && clk_en_in) |=> (sar == 12'h000 && state == sac_pkg::SAC_ACQ))
		else $error("start did not clear sar");
	no_restart_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(state == sac_pkg::SAC_CONV && !tick) |=> (state == sac_pkg::SAC_CONV))
		else $error("conversion interrupted");
	msb_first_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		($rose(state == sac_pkg::SAC_CONV)) |-> (trial == 12'h800))
		else $error("first trial not msb");
	result_hold_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(idle && $past(idle)) |-> $stable(latch))
		else $error("result changed while idle");
	end_busy_low_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(state == sac_pkg::SAC_CONV && tick && last_bit && clk_en_in) |=> !conversion_busy_flag_out)
		else $error("busy stayed high at end");
	acq_two_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		($rose(state == sac_pkg::SAC_CONV)) |-> ($past(acq_cnt) == 2'h1))
		else $error("acquisition not two cycles");
	sar_keep_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(state == sac_pkg::SAC_CONV && tick && clk_en_in && cmp_b) |=> (sar & $past(trial)) != 12'h000)
		else $error("trial bit dropped");
	sar_clear_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(step_conv && clk_en_in && !cmp_b) |=> ((sar & $past(trial)) == 12'h000))
		else $error("trial bit kept above input");
	conv_time_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$fell(conversion_busy_flag_out) |-> (conv_len == 12'(CONV_LEN)))
		else $error("conversion length wrong");
	busy_on_start_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$rose(conversion_busy_flag_out) |-> $past(start_accept))
		else $error("busy rose without start");
	restart_ignored_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(state == sac_pkg::SAC_CONV && start_pulse && !tick) |=> (state == sac_pkg::SAC_CONV && $stable(trial)))
		else $error("start during busy disturbed conversion");
	result_match_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		$fell(conversion_busy_flag_out) |-> (latch == sar))
		else $error("result differs from sar");
	trial_onehot_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(state == sac_pkg::SAC_CONV) |-> $onehot(trial))
		else $error("trial not a single bit");
	low_bits_clear_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(state == sac_pkg::SAC_CONV) |-> ((sar & (trial | (trial - 12'h001))) == 12'h000))
		else $error("untested sar bit set");
	acq_sar_zero_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(state == sac_pkg::SAC_ACQ) |-> (sar == 12'h000 && trial == 12'h000))
		else $error("sar not zero in acquisition");
	freeze_hold_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!clk_en_in |=> ($stable(state) && $stable(sar) && $stable(trial) && $stable(latch)))
		else $error("state moved while frozen");
endmodule : sac_ctrl

// ### sac_defs.svh
// Timing and layout constants for the SAR conversion control block.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH
`define SAC_RES_BITS 12
`define SAC_ACQ_CYCLES 2
`define SAC_CLK_PERIOD_PS 5000
`define SAC_CONV_TIME_NS 8000
`define SAC_CONV_CYCLES ((`SAC_CONV_TIME_NS * 1000) / `SAC_CLK_PERIOD_PS)
`define SAC_STEP_CYCLES (`SAC_CONV_CYCLES / (`SAC_RES_BITS + `SAC_ACQ_CYCLES))
`define SAC_RESULT_RST 12'h000
`endif

// ### sac_host_model.sv
// Far-side model: analog input and comparator seen by the SAR.
// Assumes the DAC word holds steady for many clocks per trial bit.
`timescale 1ns/1ps
module sac_host_model (
	// Analog side
	input wire logic [11:0] dac_in,
	input wire logic [11:0] level_in,
	output logic below_out
);
	// Input sits half an LSB above level_in
	assign below_out = {dac_in, 1'b0} < {level_in, 1'b1};
endmodule : sac_host_model

// ### sac_pkg.sv
// Types shared by the SAR conversion control block.
// No dependencies.
package sac_pkg;
	typedef enum logic [2:0] {
		SAC_IDLE = 3'h1,
		SAC_ACQ = 3'h2,
		SAC_CONV = 3'h4
	} sac_state_e;
	typedef logic [11:0] sac_word_t;
endpackage : sac_pkg

// ### sac_tick.sv
// Internal conversion clock divider: pulses once per conversion step.
// Runs only while run_in and clk_en_in are high; restarts from zero when run_in rises, holds while clk_en_in is low.
`timescale 1ns/1ps
`include "sac_defs.svh"
module sac_tick (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	// Control
	input wire logic run_in,
	output logic tick_out
);
	localparam int unsigned STEP = `SAC_STEP_CYCLES;
	logic [15:0] count;
	wire last_count = (count == 16'(STEP - 1));
	assign tick_out = run_in && last_count;
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			count <= 16'h0000;
		end else if (clk_en_in) begin
			if (!run_in || last_count) begin
				count <= 16'h0000;
			end else begin
				count <= count + 16'h0001;
			end
		end
	end
endmodule : sac_tick

// ### test_sar_adc_conversion_control.sv
// Self-checking bench for the SAR conversion control block.
// Assumes sac_ctrl, its header and the host model are compiled first.
`timescale 1ns/1ps
`include "sac_defs.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fails++; \
$display("BAD %s exp %0h got %0h", n, e, s); end end
module test_sar_adc_conversion_control;
	logic sys_clk_in, rst_in, en, ce, cs_n, rc_n, below, busy, hold;
	logic [11:0] dac, res, oe, level;
	int fails = 0;
	int checks = 0;
	int cyc = 0;
	int n;
	sac_ctrl dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(en),
		.chip_enable_in(ce), .chip_select_n_in(cs_n), .read_convert_n_in(rc_n),
		.comparator_below_in(below), .capacitive_dac_out(dac), .sample_hold_out(hold),
		.conversion_busy_flag_out(busy), .result_out(res), .result_oe_out(oe));
	sac_host_model host (.dac_in(dac), .level_in(level), .below_out(below));
	task final_report;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report
	initial begin
		sys_clk_in = 0;
		forever #2.5 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			final_report();
		end
	end
	// One conversion; sel picks which control input goes active last
	task automatic convert(input logic [11:0] code, input int sel, input bit retrig,
		input bit stall);
		level = code;
		ce = (sel != 1);
		cs_n = (sel == 2);
		rc_n = (sel == 0);
		repeat (5) @(posedge sys_clk_in);
		#1;
		`CHK("idle", 1'b0, busy)
		ce = 1;
		cs_n = 0;
		rc_n = 0;
		n = 0;
		while (busy !== 1'b1 && n < 20) begin
			@(posedge sys_clk_in);
			#1;
			n++;
		end
		`CHK("start", 1'b1, busy)
		n = 0;
		while (busy === 1'b1 && n < 3000) begin
			if (n == 5)
				`CHK("acq", 1'b0, hold)
			if (n == 410)
				`CHK("oe busy", 12'h000, oe)
			if (n == 300)
				`CHK("held", 1'b1, hold)
			if (n == 400)
				rc_n = 1;
			if (stall && n == 600)
				en = 0;
			if (stall && n == 650)
				en = 1;
			if (retrig && n == 420)
				rc_n = 0;
			@(posedge sys_clk_in);
			#1;
			n++;
		end
		`CHK("length", 14 * `SAC_STEP_CYCLES + (stall ? 50 : 0), n)
		rc_n = 1;
		repeat (6) @(posedge sys_clk_in);
		#1;
		`CHK("oe", 12'hFFF, oe)
		`CHK("result", code, res)
		repeat (20) @(posedge sys_clk_in);
		#1;
		`CHK("reread", code, res)
	endtask : convert
	// Read/convert goes active last
	task automatic scen_rc_last;
		convert(12'hA5A, 0, 0, 0);
	endtask : scen_rc_last
	// Chip enable goes active last, clock enable dropped mid-conversion
	task automatic scen_ce_last_stall;
		convert(12'h000, 1, 0, 1);
	endtask : scen_ce_last_stall
	// Chip select goes active last, start repeated while busy
	task automatic scen_cs_last_retrig;
		convert(12'hFFF, 2, 1, 0);
	endtask : scen_cs_last_retrig
	// Read/convert last, start repeated while busy
	task automatic scen_rc_last_retrig;
		convert(12'h801, 0, 1, 0);
	endtask : scen_rc_last_retrig
	initial begin
		rst_in = 1;
		en = 1;
		ce = 1;
		cs_n = 0;
		rc_n = 1;
		level = 12'h000;
		repeat (6) @(posedge sys_clk_in);
		#1;
		rst_in = 0;
		`CHK("rst busy", 1'b0, busy)
		`CHK("rst result", 12'h000, res)
		scen_rc_last();
		scen_ce_last_stall();
		scen_cs_last_retrig();
		scen_rc_last_retrig();
		final_report();
	end
endmodule : test_sar_adc_conversion_control
